// ==== logic/ilm_regs.vh ====
// register offsets, fields, reset values and timing of the level-mask interrupt block
`ifndef ILM_REGS_VH
`define ILM_REGS_VH

`define ILM_ADR_CFG      8'h00
`define ILM_ADR_RMASK_LO 8'h04
`define ILM_ADR_RMASK_HI 8'h08
`define ILM_ADR_FRC_LO   8'h0c
`define ILM_ADR_FRC_HI   8'h10
`define ILM_ADR_CLM      8'h14
`define ILM_ADR_SLM      8'h18
`define ILM_ADR_FACK     8'h1c
`define ILM_ADR_NACK     8'h20
`define ILM_ADR_ACT_LO   8'h24
`define ILM_ADR_ACT_HI   8'h28
`define ILM_ADR_EVT      8'h2c
`define ILM_ADR_EMASK    8'h30
`define ILM_ADR_LVL_BASE 3'h2

`define ILM_CFG_SPLIT_LSB 0
`define ILM_CFG_HWEN_BIT  8
`define ILM_CFG_WAKE_LSB  12
`define ILM_CFG_RST       32'h0000_0100

`define ILM_RMASK_RST     32'hffff_ffff
`define ILM_LMASK_RST     5'h1f
`define ILM_WAKE_MAX      4'hf
`define ILM_WAKE_CLAMP    4'he
`define ILM_VEC_BASE      2'h1
`define ILM_VEC_SPURIOUS  8'h3f
`define ILM_EVT_SPUR_BIT  0
`define ILM_EVT_WAKE_BIT  1
`define ILM_ACK_WAIT      2

`endif

// ==== logic/ilm_prio.v ====
// picks the highest level, then highest numbered, candidate source
`default_nettype none

module ilm_prio (
    input  wire [63:0]  cand_i,
    input  wire [255:0] lvl_i,
    output reg          found_o,
    output reg  [5:0]   idx_o,
    output reg  [3:0]   lvl_o
);

    integer n;

    // ascending scan with >= so ties go to the higher source number
    always @* begin
        found_o = 1'b0;
        idx_o   = 6'h00;
        lvl_o   = 4'h0;
        for (n = 0; n < 64; n = n + 1) begin
            if (cand_i[n] && (!found_o || lvl_i[n*4 +: 4] >= lvl_o)) begin
                found_o = 1'b1;
                idx_o   = n[5:0];
                lvl_o   = lvl_i[n*4 +: 4];
            end
        end
    end

endmodule

`default_nettype wire

// ==== logic/ilm_top.v ====
// level-masking interrupt controller with wishbone register slave
//
// Implementation choices: the Wishbone register port and the register addresses.
`include "ilm_regs.vh"
`default_nettype none

module ilm_top #(
    parameter WAIT_STATES = `ILM_ACK_WAIT
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [63:0] req_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire        wb_ack_o,
    output wire        wb_err_o,
    output wire        fast_irq_o,
    output wire        normal_irq_o,
    output wire        wake_o,
    output wire        irq_o
);

    // level at or above the split goes to the fast line
    function fast_map;
        input [3:0] lvl;
        input [4:0] split;
        begin
            fast_map = ({1'b0, lvl} >= split);
        end
    endfunction

    // byte-lane merge of a write into a stored word
    function [31:0] merge;
        input [31:0] old;
        input [31:0] wdat;
        input [3:0]  sel;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (sel[b]) begin
                    merge[b*8 +: 8] = wdat[b*8 +: 8];
                end
            end
        end
    endfunction

    reg  [63:0]  req_q;
    reg  [31:0]  cfg_q;
    reg  [63:0]  rmask_q;
    reg  [63:0]  frc_q;
    reg  [4:0]   clm_q;
    reg  [4:0]   slm_q;
    reg  [3:0]   lvl_q [0:63];
    reg  [1:0]   evt_q;
    reg  [1:0]   emask_q;
    reg  [3:0]   wait_q;
    reg          ack_q;
    reg          err_q;
    reg  [31:0]  dat_q;
    reg          fast_q;
    reg          normal_q;
    reg          wake_q;
    reg          irq_q;

    reg  [63:0]  act;
    reg  [63:0]  fsrc;
    reg  [63:0]  wk_act;
    reg  [255:0] lvl_flat;
    reg  [3:0]   wake_thr;
    reg  [31:0]  rd_d;
    reg          bad_d;
    reg  [1:0]   evt_d;

    wire [4:0]   split = cfg_q[`ILM_CFG_SPLIT_LSB +: 5];
    wire         hwen  = cfg_q[`ILM_CFG_HWEN_BIT];
    wire [3:0]   wlvl  = cfg_q[`ILM_CFG_WAKE_LSB +: 4];
    wire         req   = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
    wire         fire  = req & (wait_q == WAIT_STATES - 1);
    wire         is_fack = (wb_adr_i == `ILM_ADR_FACK);
    wire         is_nack = (wb_adr_i == `ILM_ADR_NACK);
    wire         ack_rd  = fire & ~wb_we_i & (is_fack | is_nack);
    wire         lvl_hit = (wb_adr_i[7:5] == `ILM_ADR_LVL_BASE) & (wb_adr_i[1:0] == 2'h0);
    wire [2:0]   lvl_wd  = wb_adr_i[4:2];

    wire         pr_found;
    wire [5:0]   pr_idx;
    wire [3:0]   pr_lvl;
    wire [7:0]   vec = pr_found ? {`ILM_VEC_BASE, pr_idx} : `ILM_VEC_SPURIOUS;

    // separate loop indices so that no two processes drive the same variable
    integer n;
    integer m;
    integer k;

    // register map, all words 32 bits wide, byte lanes honoured:
    //   0x00 config: [4:0] split, [8] hardware level masking, [15:12] wake threshold
    //   0x04 / 0x08 request mask low / high, all ones after reset
    //   0x0c / 0x10 force bits low / high
    //   0x14 current level mask, five bits signed, 0x1f reads as minus one
    //   0x18 saved level mask, same layout
    //   0x1c fast acknowledge read, 0x20 normal acknowledge read
    //   0x24 / 0x28 active request bits low / high, readable with core irqs off
    //   0x2c event status, read clears: bit 0 spurious ack, bit 1 wake rise
    //   0x30 event mask, same layout as the status
    //   0x40 .. 0x5c source levels, one nibble per source, eight per word
    //
    // bus timing: a request seen in cycle 0 is answered in cycle 2, so every
    // access, acknowledge reads included, spends two wait states before ack or err.
    // the write and the acknowledge side effects land at the edge that raises
    // ack, so a read issued right after sees the new value.
    //
    // hazards a user must keep in mind:
    //   - the acknowledge read picks its source from the same cycle's active
    //     set, so a source that drops in that cycle gives the spurious vector
    //   - the level masks only move on an acknowledge while hardware masking
    //     is on; with it off the current mask is not compared either
    //   - a write to either acknowledge register is refused with err and has
    //     no side effect on the masks
    //   - request lines lag the inputs by two edges; a masked source can still
    //     leave the line high for one more cycle after the mask is written
    //
    // the core lines are plain levels: the core decides when to take them,
    // and the block never touches the requesting peripheral.

    // recognition: pending and unmasked or forced, and, with hardware masking on, level above the current mask
    always @* begin
        wake_thr = (wlvl == `ILM_WAKE_MAX) ? `ILM_WAKE_CLAMP : wlvl;
        for (n = 0; n < 64; n = n + 1) begin
            act[n] = ((req_q[n] & ~rmask_q[n]) | frc_q[n]) &
                     (~hwen | ($signed({1'b0, lvl_q[n]}) > $signed(clm_q)));
            fsrc[n] = fast_map(lvl_q[n], split);
            wk_act[n] = req_q[n] & ~rmask_q[n] & (lvl_q[n] > wake_thr);
            lvl_flat[n*4 +: 4] = lvl_q[n];
        end
    end

    // highest candidate of the line being acknowledged
    ilm_prio u_prio (
        .cand_i  (act & (is_fack ? fsrc : ~fsrc)),
        .lvl_i   (lvl_flat),
        .found_o (pr_found),
        .idx_o   (pr_idx),
        .lvl_o   (pr_lvl)
    );

    // request path: input stage then line stage, core sees it two cycles on
    always @(posedge clk_i) begin
        if (rst_i) begin
            req_q    <= 64'h0;
            fast_q   <= 1'b0;
            normal_q <= 1'b0;
            wake_q   <= 1'b0;
        end else begin
            req_q    <= req_i;
            fast_q   <= |(act & fsrc);
            normal_q <= |(act & ~fsrc);
            wake_q   <= |wk_act;
        end
    end

    // read mux and address check
    always @* begin
        rd_d  = 32'h0;
        bad_d = 1'b0;
        if (lvl_hit) begin
            for (m = 0; m < 8; m = m + 1) begin
                rd_d[m*4 +: 4] = lvl_q[{lvl_wd, m[2:0]}];
            end
        end else begin
            case (wb_adr_i)
                `ILM_ADR_CFG:      rd_d = cfg_q;
                `ILM_ADR_RMASK_LO: rd_d = rmask_q[31:0];
                `ILM_ADR_RMASK_HI: rd_d = rmask_q[63:32];
                `ILM_ADR_FRC_LO:   rd_d = frc_q[31:0];
                `ILM_ADR_FRC_HI:   rd_d = frc_q[63:32];
                `ILM_ADR_CLM:      rd_d = {27'h0, clm_q};
                `ILM_ADR_SLM:      rd_d = {27'h0, slm_q};
                `ILM_ADR_FACK:     rd_d = {24'h0, vec};
                `ILM_ADR_NACK:     rd_d = {24'h0, vec};
                `ILM_ADR_ACT_LO:   rd_d = act[31:0];
                `ILM_ADR_ACT_HI:   rd_d = act[63:32];
                `ILM_ADR_EVT:      rd_d = {30'h0, evt_q};
                `ILM_ADR_EMASK:    rd_d = {30'h0, emask_q};
                default:           bad_d = 1'b1;
            endcase
        end
    end

    // sticky events: a new event wins over the clear of a status read
    always @* begin
        evt_d = evt_q;
        if (fire & ~wb_we_i & (wb_adr_i == `ILM_ADR_EVT)) begin
            evt_d = 2'h0;
        end
        if (ack_rd & ~pr_found) begin
            evt_d[`ILM_EVT_SPUR_BIT] = 1'b1;
        end
        if (|wk_act & ~wake_q) begin
            evt_d[`ILM_EVT_WAKE_BIT] = 1'b1;
        end
    end

    // bus slave, register writes and acknowledge side effects
    always @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q   <= `ILM_CFG_RST;
            rmask_q <= {`ILM_RMASK_RST, `ILM_RMASK_RST};
            frc_q   <= 64'h0;
            clm_q   <= `ILM_LMASK_RST;
            slm_q   <= `ILM_LMASK_RST;
            evt_q   <= 2'h0;
            emask_q <= 2'h0;
            wait_q  <= 4'h0;
            ack_q   <= 1'b0;
            err_q   <= 1'b0;
            dat_q   <= 32'h0;
            irq_q   <= 1'b0;
            for (k = 0; k < 64; k = k + 1) begin
                lvl_q[k] <= 4'h0;
            end
        end else begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            evt_q <= evt_d;
            irq_q <= |(evt_d & emask_q);
            if (!req) begin
                wait_q <= 4'h0;
            end else if (!fire) begin
                wait_q <= wait_q + 4'h1;
            end else begin
                wait_q <= 4'h0;
                dat_q  <= wb_we_i ? 32'h0 : rd_d;
                if (bad_d | (wb_we_i & (is_fack | is_nack))) begin
                    err_q <= 1'b1;
                end else begin
                    ack_q <= 1'b1;
                end
                if (ack_rd & pr_found & hwen) begin
                    slm_q <= clm_q;
                    clm_q <= {1'b0, pr_lvl};
                end
                if (wb_we_i & ~bad_d) begin
                    case (wb_adr_i)
                        `ILM_ADR_CFG:
                            cfg_q <= merge(cfg_q, wb_dat_i, wb_sel_i) & 32'h0000_f11f;
                        `ILM_ADR_RMASK_LO:
                            rmask_q[31:0] <= merge(rmask_q[31:0], wb_dat_i, wb_sel_i);
                        `ILM_ADR_RMASK_HI:
                            rmask_q[63:32] <= merge(rmask_q[63:32], wb_dat_i, wb_sel_i);
                        `ILM_ADR_FRC_LO:
                            frc_q[31:0] <= merge(frc_q[31:0], wb_dat_i, wb_sel_i);
                        `ILM_ADR_FRC_HI:
                            frc_q[63:32] <= merge(frc_q[63:32], wb_dat_i, wb_sel_i);
                        `ILM_ADR_CLM:
                            if (wb_sel_i[0]) clm_q <= wb_dat_i[4:0];
                        `ILM_ADR_SLM:
                            if (wb_sel_i[0]) slm_q <= wb_dat_i[4:0];
                        `ILM_ADR_EMASK:
                            if (wb_sel_i[0]) emask_q <= wb_dat_i[1:0];
                        default: begin
                            if (lvl_hit) begin
                                for (k = 0; k < 8; k = k + 1) begin
                                    if (wb_sel_i[k/2]) begin
                                        lvl_q[{lvl_wd, k[2:0]}] <= wb_dat_i[k*4 +: 4];
                                    end
                                end
                            end
                        end
                    endcase
                end
            end
        end
    end

    assign wb_dat_o     = dat_q;
    assign wb_ack_o     = ack_q;
    assign wb_err_o     = err_q;
    assign fast_irq_o   = fast_q;
    assign normal_irq_o = normal_q;
    assign wake_o       = wake_q;
    assign irq_o        = irq_q;

endmodule

`default_nettype wire

// ==== tb/ilm_monitor.sv ====
// bus timing and request line checks for the level-mask interrupt block
`default_nettype none
module ilm_monitor #(
    parameter int WAIT_STATES = 2
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [63:0] req_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        fast_irq_o,
    input wire logic        normal_irq_o,
    input wire logic        wake_o,
    input wire logic        irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] split_q;
    // follows the split field through acknowledged config writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            split_q <= 5'h00;
        end else if (wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0]) begin
            split_q <= wb_dat_i[4:0];
        end
    end
    ack_one_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    ack_latency_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(wb_stb_i) && wb_cyc_i |-> ##WAIT_STATES (wb_ack_o || wb_err_o))
        else $error("bus answer late");
    ack_not_early_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(wb_stb_i) |=> !wb_ack_o && !wb_err_o) else $error("bus answer early");
    ack_has_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> wb_cyc_i && wb_stb_i && $past(wb_stb_i))
        else $error("ack without request");
    ack_err_excl_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wb_ack_o && wb_err_o)) else $error("ack and err together");
    reset_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> !fast_irq_o && !normal_irq_o && !wb_ack_o && !irq_o)
        else $error("output active after reset");
    split_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        split_q == 5'h00 && $past(split_q) == 5'h00 && $past(split_q, 2) == 5'h00
        |-> !normal_irq_o) else $error("normal line with split zero");
    ack_ro_err_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(wb_stb_i) && wb_cyc_i && wb_we_i && (wb_adr_i == 8'h1c || wb_adr_i == 8'h20)
        |-> ##WAIT_STATES wb_err_o) else $error("ack register write not refused");
endmodule
`default_nettype wire

// ==== tb/ilm_core.sv ====
// behavioural core: counts entries on its fast and normal request inputs
`default_nettype none
module ilm_core (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic fast_irq_i,
    input wire logic normal_irq_i,
    output var int   fiq_cnt_o,
    output var int   irq_cnt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic fast_q;
    logic norm_q;
    // a rising request line is one exception entry
    always_ff @(posedge clk_i) begin
        fast_q <= fast_irq_i & ~rst_i;
        norm_q <= normal_irq_i & ~rst_i;
        if (rst_i) begin
            fiq_cnt_o <= 0;
            irq_cnt_o <= 0;
        end else begin
            if (fast_irq_i && !fast_q) fiq_cnt_o <= fiq_cnt_o + 1;
            if (normal_irq_i && !norm_q) irq_cnt_o <= irq_cnt_o + 1;
        end
    end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the level-mask interrupt block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic        e;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'hf;
    logic [31:0] dat = 32'h0;
    logic [31:0] rnd = 32'h3988;
    logic [63:0] req = 64'h0;
    logic [39:0] exp_q[$];
    wire logic [31:0] dat_o;
    wire logic   ack, err, fiq, nirq, wake, irq;
    int          err_total = 0;
    int          n_tests = 0;
    int          cyc_cnt = 0;
    int          fiq_cnt;
    ilm_top #(.WAIT_STATES(2)) ilm_top_i (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
        .fast_irq_o(fiq), .normal_irq_o(nirq), .wake_o(wake), .irq_o(irq));
    ilm_core ilm_core_i (.clk_i(clk_i), .rst_i(rst_i), .fast_irq_i(fiq),
        .normal_irq_i(nirq), .fiq_cnt_o(fiq_cnt), .irq_cnt_o());
    // clock and hang guard
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            err_total++;
            finish_test;
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, ex, got);
        end
    endtask
    // one classic cycle, held until ack or err, then one idle cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(negedge clk_i);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
        e = err;
        if (ack !== 1'b1 && err !== 1'b1) err_total++;
        @(posedge clk_i);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        exp_q.push_back({a, x});
        bus(1'b0, a, 32'h0);
    endtask
    task automatic look(input int k);
        repeat (k) @(negedge clk_i);
    endtask
    // read data is compared with the oldest note when ack is seen
    always @(negedge clk_i) begin : watch
        logic [39:0] q;
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
            q = exp_q.pop_front();
            chk("rdata", q[31:0], dat_o);
        end
    end
    task automatic finish_test;
        if (err_total == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(8'h04, 32'hffffffff);
        rd(8'h08, 32'hffffffff);
        rd(8'h14, 32'h1f);
        rd(8'h18, 32'h1f);
        bus(1'b1, 8'h00, 32'h0000f108);
        bus(1'b1, 8'h40, 32'h00005000);
        bus(1'b1, 8'h54, 32'h0000000f);
        bus(1'b1, 8'h30, 32'h1);
        rnd = xs(rnd);
        req <= {rnd, xs(rnd)} & ~64'h0000_0100_0000_0008;
        bus(1'b1, 8'h04, 32'hfffffff7);
        bus(1'b1, 8'h08, 32'hfffffeff);
        look(3);
        chk("fiq idle", 0, fiq);
        @(posedge clk_i);
        req[40] <= 1'b1;
        look(2);
        chk("fiq i+1", 0, fiq);
        look(1);
        chk("fiq i+2", 1, fiq);
        look(1);
        chk("wake", 1, wake);
        @(posedge clk_i);
        req[3] <= 1'b1;
        look(3);
        chk("nirq", 1, nirq);
        rd(8'h24, 32'h8);
        rd(8'h28, 32'h100);
        rd(8'h1c, 32'h68);
        rd(8'h14, 32'h0f);
        rd(8'h18, 32'h1f);
        look(2);
        chk("fiq masked", 0, fiq);
        chk("nirq masked", 0, nirq);
        rd(8'h20, 32'h3f);
        rd(8'h14, 32'h0f);
        look(2);
        chk("irq", 1, irq);
        rd(8'h2c, 32'h3);
        look(2);
        chk("irq clr", 0, irq);
        @(posedge clk_i);
        req[40] <= 1'b0;
        bus(1'b1, 8'h14, 32'h1f);
        look(3);
        chk("nirq back", 1, nirq);
        rnd = xs(rnd);
        bus(1'b1, 8'h14, {27'h0, rnd[4:0]});
        rd(8'h14, {27'h0, rnd[4:0]});
        bus(1'b1, 8'h14, 32'h1f);
        bus(1'b1, 8'h00, 32'h0000f100);
        look(3);
        chk("split0 nirq", 0, nirq);
        chk("split0 fiq", 1, fiq);
        bus(1'b1, 8'h00, 32'h0000f000);
        bus(1'b1, 8'h14, 32'h03);
        rd(8'h1c, 32'h43);
        rd(8'h14, 32'h03);
        chk("fiq entries", 2, fiq_cnt);
        bus(1'b0, 8'h34, 32'h0);
        chk("err map", 1, e);
        bus(1'b1, 8'h1c, 32'h1);
        chk("err ro", 1, e);
        finish_test;
    end
endmodule
bind ilm_top ilm_monitor #(.WAIT_STATES(WAIT_STATES)) ilm_monitor_i (.clk_i(clk_i),
    .rst_i(rst_i), .req_i(req_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .fast_irq_o(fast_irq_o), .normal_irq_o(normal_irq_o), .wake_o(wake_o), .irq_o(irq_o));
`default_nettype wire
